// file: hw/bras_defines.svh
// Constants for the BCD and real accumulator arithmetic unit
`ifndef BRAS_DEFINES_SVH
`define BRAS_DEFINES_SVH

// ======================================================================
// Widths
`define BRAS_ACC_W        32
`define BRAS_DIGITS       8
`define BRAS_SHORT_DIGITS 4
`define BRAS_SHORT_W      16

// ======================================================================
// Reset values
`define BRAS_ACC_RST      32'h0000_0000
`define BRAS_FLAGS_RST    11'h000

// ======================================================================
// BCD digit limits
`define BRAS_DIGIT_MAX    4'h9
`define BRAS_DIGIT_ADJ    5'h06

// ======================================================================
// Single precision layout
`define BRAS_SIGN_POS     31
`define BRAS_EXP_HI       30
`define BRAS_EXP_LO       23
`define BRAS_FRAC_HI      22
`define BRAS_EXP_ALL1     8'hFF
`define BRAS_SUM_W        28
`define BRAS_LEAD_POS     5'h1B
`define BRAS_UNIT_POS     10'h01A
`define BRAS_EXP_OVF      10'h0FF
// Addend 2^26 times smaller is lost in alignment
`define BRAS_ALIGN_LIMIT  8'h1A
`define BRAS_REAL_INF     31'h7F80_0000

`endif

// file: hw/bras_pkg.sv
// Types for the BCD and real accumulator arithmetic unit
package bras_pkg;

   // ===================================================================
   // Instructions
   typedef enum logic [1:0] {
      BRAS_OP_ADD16,
      BRAS_OP_ADD32,
      BRAS_OP_ADDREAL,
      BRAS_OP_SUB16
   } bras_op_t;

   // ===================================================================
   // Request from the sequencer
   typedef struct packed {
      bras_op_t    op;
      logic [31:0] operand;
      logic        ptr_bad;
   } bras_req_t;

   // ===================================================================
   // Discrete status flags
   typedef struct packed {
      logic zero_result_flag;
      logic short_borrow_flag;
      logic long_borrow_flag;
      logic short_carry_flag;
      logic long_carry_flag;
      logic negative_result_flag;
      logic bad_pointer_flag;
      logic valid_real_flag;
      logic sign_error_flag;
      logic underflow_flag;
      logic invalid_operand_flag;
   } bras_flags_t;

endpackage : bras_pkg

// file: hw/bras_acc_unit.sv
// Accumulator arithmetic unit: BCD add and subtract, real add, status flags
//
// Operation
// [RQ1] Single add: 16-bit BCD memory plus accumulator
// [RQ2] Double add: 32-bit BCD memory or constant
// [RQ3] Real add: IEEE single operand into accumulator
// [RQ4] Single subtract: 16-bit BCD from accumulator
// [RQ5] Zero flag when result accumulator is zero
// [RQ6] Short carry on 16-bit BCD carry out
// [RQ7] Long carry on 32-bit BCD carry out
// [RQ8] Short borrow when subtrahend exceeds low word
// [RQ9] Long borrow flag, cleared by single subtract
// [RQ10] Negative flag when result is negative
// [RQ11] Invalid operand on any non-decimal nibble
// [RQ12] Invalid operand on non-valid IEEE operand
// [RQ13] Bad pointer flag on invalid pointer target
// [RQ14] Valid real flag after real add
// [RQ15] Sign error flag on real overflow
// [RQ16] Underflow flag on too-small real result
// [RQ17] Sequencer treats flags valid until overwritten
// [RQ18] Tiny addend may be lost in alignment
// [RQ19] Undefined flags kept, defined flags written
// [RQ20] 16-bit ops clear upper accumulator word
`timescale 1ns/1ps
`include "bras_defines.svh"

module bras_acc_unit (
   input  wire logic               sys_clk_i,
   input  wire logic               srst_i,
   input  wire logic               req_valid_i,
   input  wire bras_pkg::bras_req_t req_i,
   input  wire logic               acc_load_i,
   input  wire logic [31:0]        acc_load_data_i,
   output logic                    done_o,
   output logic [31:0]             acc_o,
   output bras_pkg::bras_flags_t   flags_o
);

   // ===================================================================
   // Operand decode
   logic        is_short;
   logic        is_sub;
   logic        is_real;
   logic [31:0] acc_q;
   logic [31:0] acc_d;
   logic [31:0] opnd;

   assign opnd     = req_i.operand;
   assign is_short = (req_i.op == bras_pkg::BRAS_OP_ADD16) ||
                     (req_i.op == bras_pkg::BRAS_OP_SUB16);
   assign is_sub   = (req_i.op == bras_pkg::BRAS_OP_SUB16);
   assign is_real  = (req_i.op == bras_pkg::BRAS_OP_ADDREAL);

   // ===================================================================
   // BCD digit chain
   logic [`BRAS_DIGITS:0]   bcd_c;
   logic [31:0]             bcd_sum;
   logic [`BRAS_DIGITS-1:0] bad_digit;

   // Ten's complement subtract: nines digits with carry in
   assign bcd_c[0] = is_sub;

   genvar gi;
   generate
      for (gi = 0; gi < `BRAS_DIGITS; gi++) begin : g_digit
         logic       used;
         logic [3:0] da;
         logic [3:0] db;
         logic [3:0] db_eff;
         logic [4:0] raw;
         logic [4:0] adj;

         assign used = (gi < `BRAS_SHORT_DIGITS) || !is_short;
         assign da   = used ? acc_q[gi*4 +: 4] : 4'h0;
         assign db   = used ? opnd[gi*4 +: 4] : 4'h0;
         // [RQ4] Nines complement subtrahend
         assign db_eff = is_sub ? (`BRAS_DIGIT_MAX - db) : db;
         // [RQ1] [RQ2] Decimal digit add
         assign raw = {1'b0, da} + {1'b0, db_eff} + {4'h0, bcd_c[gi]};
         assign adj = (raw > {1'b0, `BRAS_DIGIT_MAX}) ? (raw + `BRAS_DIGIT_ADJ) : raw;
         assign bcd_c[gi+1]        = raw > {1'b0, `BRAS_DIGIT_MAX};
         assign bcd_sum[gi*4 +: 4] = adj[3:0];
         // [RQ11] Non-decimal nibble check
         assign bad_digit[gi] = used &&
                                ((da > `BRAS_DIGIT_MAX) || (db > `BRAS_DIGIT_MAX));
      end
   endgenerate

   logic        bcd_bad;
   logic [31:0] bcd_res;

   assign bcd_bad = |bad_digit;
   // [RQ20] Upper word cleared on short ops
   assign bcd_res = is_short ? {16'h0000, bcd_sum[15:0]} : bcd_sum;

   // ===================================================================
   // Real add: unpack and order by magnitude
   logic        a_big;
   logic [31:0] big;
   logic [31:0] sml;
   logic [7:0]  e_big;
   logic [7:0]  e_sml;
   logic [23:0] m_big;
   logic [23:0] m_sml;
   logic        real_bad;

   // [RQ12] Infinity or NaN is not a usable real
   assign real_bad = (acc_q[`BRAS_EXP_HI:`BRAS_EXP_LO] == `BRAS_EXP_ALL1) ||
                     (opnd[`BRAS_EXP_HI:`BRAS_EXP_LO] == `BRAS_EXP_ALL1);
   assign a_big = acc_q[30:0] >= opnd[30:0];
   assign big   = a_big ? acc_q : opnd;
   assign sml   = a_big ? opnd : acc_q;
   assign e_big = big[`BRAS_EXP_HI:`BRAS_EXP_LO];
   assign e_sml = sml[`BRAS_EXP_HI:`BRAS_EXP_LO];
   // Denormals flushed to zero, keeps the adder small
   assign m_big = (e_big == 8'h00) ? 24'h000000 : {1'b1, big[`BRAS_FRAC_HI:0]};
   assign m_sml = (e_sml == 8'h00) ? 24'h000000 : {1'b1, sml[`BRAS_FRAC_HI:0]};

   // ===================================================================
   // Real add: align, add, normalise
   logic [7:0]            e_diff;
   logic [`BRAS_SUM_W-1:0] x_big;
   logic [`BRAS_SUM_W-1:0] x_sml;
   logic [`BRAS_SUM_W-1:0] r_sum;
   logic [`BRAS_SUM_W-1:0] r_norm;
   logic [4:0]            lead;
   logic signed [9:0]     e_res;
   logic                  r_zero;
   logic                  r_ovf;
   logic                  r_unf;
   logic [31:0]           real_res;

   assign e_diff = e_big - e_sml;
   assign x_big  = {1'b0, m_big, 3'b000};
   // [RQ18] Addend beyond alignment range is dropped
   assign x_sml  = (e_diff >= `BRAS_ALIGN_LIMIT) ? '0 : ({1'b0, m_sml, 3'b000} >> e_diff);
   // [RQ3] Same signs add, differing signs subtract
   assign r_sum  = (big[`BRAS_SIGN_POS] == sml[`BRAS_SIGN_POS]) ? (x_big + x_sml)
                                                                : (x_big - x_sml);

   always_comb begin
      lead = 5'h00;
      for (int i = 0; i < `BRAS_SUM_W; i++) begin
         if (r_sum[i]) begin
            lead = i[4:0];
         end
      end
   end

   assign r_norm = r_sum << (`BRAS_LEAD_POS - lead);
   assign e_res  = $signed({2'b00, e_big}) + $signed({5'h00, lead}) -
                   $signed(`BRAS_UNIT_POS);
   assign r_zero = (r_sum == '0);
   // [RQ15] Exponent overflow gives a signed infinity result
   assign r_ovf  = !r_zero && (e_res >= $signed(`BRAS_EXP_OVF));
   // [RQ16] Result below smallest normal
   assign r_unf  = !r_zero && (e_res <= $signed(10'h000));

   always_comb begin
      if (r_zero || r_unf) begin
         real_res = 32'h0000_0000;
      end else if (r_ovf) begin
         real_res = {big[`BRAS_SIGN_POS], `BRAS_REAL_INF};
      end else begin
         // Truncating rounding, no sticky bit
         real_res = {big[`BRAS_SIGN_POS], e_res[7:0], r_norm[26:4]};
      end
   end

   // ===================================================================
   // Result select
   logic op_bad;

   assign op_bad = is_real ? real_bad : bcd_bad;

   always_comb begin
      acc_d = acc_q;
      if (req_valid_i) begin
         // Bad pointer or bad operand leaves accumulator untouched
         if (!req_i.ptr_bad && !op_bad) begin
            acc_d = is_real ? real_res : bcd_res;
         end
      end else if (acc_load_i) begin
         acc_d = acc_load_data_i;
      end
   end

   // ===================================================================
   // Next flag values and which ones this op defines
   bras_pkg::bras_flags_t flags_q;
   bras_pkg::bras_flags_t fl_new;
   bras_pkg::bras_flags_t fl_def;
   logic                  acc_real_neg;

   assign acc_real_neg = acc_d[`BRAS_SIGN_POS] && (acc_d[30:0] != 31'h0000_0000);

   always_comb begin
      fl_new = '0;
      fl_def = '0;
      // [RQ5] Zero flag on every op
      fl_new.zero_result_flag     = (acc_d == 32'h0000_0000);
      fl_def.zero_result_flag     = 1'b1;
      // [RQ13] Pointer validity on every op
      fl_new.bad_pointer_flag     = req_i.ptr_bad;
      fl_def.bad_pointer_flag     = 1'b1;
      // [RQ11] [RQ12] Operand validity on every op
      fl_new.invalid_operand_flag = op_bad;
      fl_def.invalid_operand_flag = 1'b1;
      fl_def.negative_result_flag = 1'b1;
      unique case (req_i.op)
         bras_pkg::BRAS_OP_ADD16: begin
            // [RQ6] Carry out of fourth digit
            fl_new.short_carry_flag = bcd_c[`BRAS_SHORT_DIGITS] && !op_bad && !req_i.ptr_bad;
            fl_def.short_carry_flag = 1'b1;
            fl_def.long_carry_flag  = 1'b1;
         end
         bras_pkg::BRAS_OP_ADD32: begin
            fl_new.short_carry_flag = bcd_c[`BRAS_SHORT_DIGITS] && !op_bad && !req_i.ptr_bad;
            fl_def.short_carry_flag = 1'b1;
            // [RQ7] Carry out of eighth digit
            fl_new.long_carry_flag  = bcd_c[`BRAS_DIGITS] && !op_bad && !req_i.ptr_bad;
            fl_def.long_carry_flag  = 1'b1;
         end
         bras_pkg::BRAS_OP_SUB16: begin
            // [RQ8] No carry out means subtrahend was larger
            fl_new.short_borrow_flag    = !bcd_c[`BRAS_SHORT_DIGITS] && !op_bad &&
                                          !req_i.ptr_bad;
            fl_def.short_borrow_flag    = 1'b1;
            // [RQ9] Long borrow written clear here
            fl_def.long_borrow_flag     = 1'b1;
            // [RQ10] Wrapped difference is a negative result
            fl_new.negative_result_flag = fl_new.short_borrow_flag;
         end
         bras_pkg::BRAS_OP_ADDREAL: begin
            // [RQ10] Sign of nonzero real result
            fl_new.negative_result_flag = acc_real_neg;
            // [RQ14] Finite result in accumulator
            fl_new.valid_real_flag      = acc_d[`BRAS_EXP_HI:`BRAS_EXP_LO] != `BRAS_EXP_ALL1;
            fl_def.valid_real_flag      = 1'b1;
            // [RQ15] Overflow reported as sign error
            fl_new.sign_error_flag      = r_ovf && !op_bad && !req_i.ptr_bad;
            fl_def.sign_error_flag      = 1'b1;
            // [RQ16] Flushed tiny result
            fl_new.underflow_flag       = r_unf && !op_bad && !req_i.ptr_bad;
            fl_def.underflow_flag       = 1'b1;
         end
      endcase
   end

   // ===================================================================
   // Accumulator
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         acc_q <= `BRAS_ACC_RST;
      end else begin
         acc_q <= acc_d;
      end
   end

   // ===================================================================
   // Status flags
   // [RQ17] Flags hold until the next op that defines them
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         flags_q <= `BRAS_FLAGS_RST;
      end else if (req_valid_i) begin
         // [RQ19] Merge defined flags only
         flags_q <= (flags_q & ~fl_def) | (fl_new & fl_def);
      end
   end

   // ===================================================================
   // Completion pulse
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         done_o <= 1'b0;
      end else begin
         done_o <= req_valid_i;
      end
   end

   assign acc_o   = acc_q;
   assign flags_o = flags_q;

endmodule : bras_acc_unit

// file: tb/bras_acc_unit_sva.sv
// Assertions on the accumulator unit ports
`timescale 1ns/1ps
module bras_acc_unit_sva (
   input wire logic                  sys_clk_i,
   input wire logic                  srst_i,
   input wire logic                  req_valid_i,
   input wire bras_pkg::bras_req_t   req_i,
   input wire logic                  acc_load_i,
   input wire logic [31:0]           acc_load_data_i,
   input wire logic                  done_o,
   input wire logic [31:0]           acc_o,
   input wire bras_pkg::bras_flags_t flags_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   logic a16;
   logic s16;
   logic rl;
   assign a16 = req_valid_i && req_i.op == bras_pkg::BRAS_OP_ADD16;
   assign s16 = req_valid_i && req_i.op == bras_pkg::BRAS_OP_SUB16;
   assign rl  = req_valid_i && req_i.op == bras_pkg::BRAS_OP_ADDREAL;
   // ===================================================================
   // Properties
   a_done_pulse: assert property (req_valid_i |=> done_o)
      else $error("done missing");
   a_done_cause: assert property (!req_valid_i |=> !done_o)
      else $error("stray done");
   a_upper_clear: assert property (a16 || s16 |=>
      acc_o[31:16] == 16'h0000 || acc_o == $past(acc_o)) else $error("upper word kept");
   a_bcd_zero: assert property (req_valid_i && !rl |=>
      flags_o.zero_result_flag == (acc_o == 32'h0000_0000)) else $error("zero flag");
   a_bad_ptr: assert property (req_valid_i && req_i.ptr_bad |=>
      flags_o.bad_pointer_flag && acc_o == $past(acc_o)) else $error("bad pointer");
   a_sub_flags: assert property (s16 |=>
      !flags_o.long_borrow_flag && flags_o.negative_result_flag == flags_o.short_borrow_flag)
      else $error("sub");
   a_add_keep: assert property (a16 |=>
      !flags_o.long_carry_flag && $stable(flags_o.short_borrow_flag)) else $error("add16 flags");
   a_load_path: assert property (acc_load_i && !req_valid_i |=>
      acc_o == $past(acc_load_data_i) && $stable(flags_o)) else $error("load");
   a_real_err: assert property (rl |=>
      !(flags_o.sign_error_flag && flags_o.valid_real_flag)
      && (!flags_o.underflow_flag || acc_o == 32'h0000_0000)) else $error("real");
endmodule : bras_acc_unit_sva
bind bras_acc_unit bras_acc_unit_sva u_sva (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
   .req_valid_i(req_valid_i), .req_i(req_i), .acc_load_i(acc_load_i),
   .acc_load_data_i(acc_load_data_i), .done_o(done_o), .acc_o(acc_o), .flags_o(flags_o));

// file: tb/bras_seq_model.sv
// Sequencer and operand memory model
`timescale 1ns/1ps
module bras_seq_model (
   input  wire logic                sys_clk_i,
   output logic                     req_valid_o,
   output bras_pkg::bras_req_t      req_o,
   output logic                     acc_load_o,
   output logic [31:0]              acc_load_data_o
);
   initial begin
      req_valid_o = 1'b0;
      acc_load_o = 1'b0;
   end
   task automatic issue(input bras_pkg::bras_op_t op, input logic [31:0] d, input logic p);
      req_o = '{op, d, p};
      req_valid_o = 1'b1;
      @(posedge sys_clk_i);
      #1;
   endtask : issue
   // Released bus shows garbage, not the old word
   task automatic idle();
      req_valid_o = 1'b0;
      req_o.operand = ~req_o.operand;
   endtask : idle
   task automatic load(input logic [31:0] d);
      acc_load_o = 1'b1;
      acc_load_data_o = d;
      @(posedge sys_clk_i);
      #1;
      acc_load_o = 1'b0;
      acc_load_data_o = ~d;
   endtask : load
endmodule : bras_seq_model

// file: tb/bras_acc_unit_tb_top.sv
// Self-checking bench for the accumulator unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module bras_acc_unit_tb_top;
   localparam bras_pkg::bras_op_t A16 = bras_pkg::BRAS_OP_ADD16;
   localparam bras_pkg::bras_op_t A32 = bras_pkg::BRAS_OP_ADD32;
   localparam bras_pkg::bras_op_t AR  = bras_pkg::BRAS_OP_ADDREAL;
   localparam bras_pkg::bras_op_t S16 = bras_pkg::BRAS_OP_SUB16;
   logic                  sys_clk_i = 1'b0;
   logic                  srst_i = 1'b1;
   logic                  req_valid_i;
   bras_pkg::bras_req_t   req_i;
   logic                  acc_load_i;
   logic [31:0]           acc_load_data_i;
   logic                  done_o;
   logic [31:0]           acc_o;
   bras_pkg::bras_flags_t flags_o;
   int                    error_cnt = 0;
   int                    n_compared = 0;
   always #12.5 sys_clk_i = ~sys_clk_i;
   bras_seq_model seq (.sys_clk_i(sys_clk_i), .req_valid_o(req_valid_i), .req_o(req_i),
      .acc_load_o(acc_load_i), .acc_load_data_o(acc_load_data_i));
   bras_acc_unit DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .req_valid_i(req_valid_i),
      .req_i(req_i), .acc_load_i(acc_load_i), .acc_load_data_i(acc_load_data_i),
      .done_o(done_o), .acc_o(acc_o), .flags_o(flags_o));
   // ===================================================================
   // Shared steps
   task automatic run(input bras_pkg::bras_op_t op, input logic [31:0] d, input logic p,
      input logic [31:0] e);
      @(posedge sys_clk_i);
      #1;
      seq.issue(op, d, p);
      seq.idle();
      `CHK("done", 1'b1, done_o)
      `CHK("acc", e, acc_o)
   endtask : run
   task automatic finish_test();
      $display("compared %0d mismatched %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   // ===================================================================
   // Scenarios
   task automatic t_bcd_add();
      seq.load(32'h1234_9999);
      run(A16, 32'h0000_0001, 1'b0, 32'h0000_0000);
      `CHK("flags", 11'h480, flags_o)
      seq.issue(A16, 32'h0000_0004, 1'b0);
      seq.issue(A16, 32'h0000_0005, 1'b0);
      seq.idle();
      `CHK("acc", 32'h0000_0009, acc_o)
      seq.load(32'h9999_9999);
      run(A32, 32'h0000_0001, 1'b0, 32'h0000_0000);
      `CHK("flags", 11'h4C0, flags_o)
      run(A32, 32'h1234_5678, 1'b0, 32'h1234_5678);
      `CHK("flags", 11'h000, flags_o)
   endtask : t_bcd_add
   task automatic t_bcd_sub();
      seq.load(32'h0000_0005);
      run(S16, 32'h0000_0007, 1'b0, 32'h0000_9998);
      `CHK("flags", 11'h220, flags_o)
      run(A16, 32'h0000_0002, 1'b0, 32'h0000_0000);
      `CHK("flags", 11'h680, flags_o)
      run(S16, 32'h0000_0000, 1'b0, 32'h0000_0000);
      `CHK("flags", 11'h480, flags_o)
   endtask : t_bcd_sub
   task automatic t_bad_input();
      seq.load(32'h0000_0001);
      run(A16, 32'h0000_000A, 1'b0, 32'h0000_0001);
      `CHK("flags", 11'h001, flags_o)
      run(A32, 32'hA000_0000, 1'b0, 32'h0000_0001);
      `CHK("flags", 11'h001, flags_o)
      run(A16, 32'h0000_0001, 1'b1, 32'h0000_0001);
      `CHK("flags", 11'h010, flags_o)
      run(A16, 32'h0000_9999, 1'b1, 32'h0000_0001);
      `CHK("flags", 11'h010, flags_o)
   endtask : t_bad_input
   task automatic t_real();
      seq.load(32'h3F80_0000);
      run(AR, 32'h3F80_0000, 1'b0, 32'h4000_0000);
      `CHK("flags", 11'h008, flags_o)
      run(AR, 32'hC040_0000, 1'b0, 32'hBF80_0000);
      `CHK("flags", 11'h028, flags_o)
      seq.load(32'h7F7F_FFFF);
      run(AR, 32'h7F7F_FFFF, 1'b0, 32'h7F80_0000);
      `CHK("flags", 11'h004, flags_o)
      seq.load(32'h0080_0001);
      run(AR, 32'h8080_0000, 1'b0, 32'h0000_0000);
      `CHK("uflow", 1'b1, flags_o.underflow_flag)
      run(AR, 32'h7FC0_0000, 1'b0, 32'h0000_0000);
      `CHK("inv", 1'b1, flags_o.invalid_operand_flag)
   endtask : t_real
   // ===================================================================
   // Main sequence and watchdog
   initial begin
      repeat (16) @(posedge sys_clk_i);
      #1;
      `CHK("acc", 32'h0000_0000, acc_o)
      `CHK("flags", 11'h000, flags_o)
      srst_i = 1'b0;
      t_bcd_add();
      t_bcd_sub();
      t_bad_input();
      t_real();
      finish_test();
   end
   // Whole run is under 200 cycles; generous margin
   initial begin
      repeat (2000) @(posedge sys_clk_i);
      error_cnt++;
      finish_test();
   end
endmodule : bras_acc_unit_tb_top
